/* File: msi_pkg.sv */
// Shared constants and types of the motion interrupt source status block.
package msi_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register addresses seen on the internal register read port.
	localparam logic [7:0] REG_SYSTEM_MODE = 8'h14;
	localparam logic [7:0] REG_INT_SOURCE = 8'h15;
	localparam logic [7:0] REG_ORIENT_STATUS = 8'h18;
	localparam logic [7:0] REG_FIFO_STATUS = 8'h40;
	localparam logic [7:0] REG_TRANSIENT_SOURCE = 8'h41;
	localparam logic [7:0] REG_TAP_SOURCE = 8'h42;
	localparam logic [7:0] REG_FALL_A_SOURCE = 8'h43;
	localparam logic [7:0] REG_FALL_B_SOURCE = 8'h44;

	////////////////////////////////////////////////////////////////////////////////
	// Bit positions inside the interrupt source status register.
	localparam int BIT_AUTOSLEEP = 7;
	localparam int BIT_FIFO = 6;
	localparam int BIT_TRANSIENT = 5;
	localparam int BIT_ORIENT = 4;
	localparam int BIT_TAP = 3;
	localparam int BIT_FALL_A = 2;
	localparam int BIT_FALL_B = 1;
	localparam int BIT_DATA_READY = 0;
	localparam int FLAG_LO = 1;
	localparam int FLAG_HI = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and fixed counts.
	localparam logic [7:0] INT_SOURCE_RESET = 8'h00;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [5:0] FIFO_FULL_COUNT = 6'h20;
	localparam logic [5:0] WATERMARK_OFF = 6'h00;
	localparam logic [8:0] IDLE_COUNT_RESET = 9'h000;
	localparam logic [8:0] IDLE_COUNT_STEP = 9'h001;
	localparam logic [2:0] RATE_RESET = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// System operating mode, as shown in the system mode register.
	typedef enum logic [1:0] {
		MSI_MODE_STANDBY = 2'b00,
		MSI_MODE_WAKE = 2'b01,
		MSI_MODE_SLEEP = 2'b10
	} msi_mode_t;

endpackage

/* File: msi_edge_flag.sv */
// Rising edge sticky status flag with read clear, used once per interrupt source.
module msi_edge_flag (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic src_i,
	input wire logic enable_i,
	input wire logic clear_i,
	output logic flag_o,
	output logic rise_o
);

	logic prev_r;
	logic flag_r;
	logic flag_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// An enabled low to high step of the source counts as one event.
	assign rise_o = src_i & ~prev_r & enable_i;
	// A new event in the clearing cycle keeps the flag set.
	assign flag_nxt = rise_o | (flag_r & ~clear_i);
	assign flag_o = flag_r;

	// Source history and the sticky flag itself.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prev_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			prev_r <= src_i;
			flag_r <= flag_nxt;
		end
	end

endmodule

/* File: msi_sleep_ctrl.sv */
// Auto-sleep and auto-wake mode controller with output rate selection.
module msi_sleep_ctrl (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic active_i,
	input wire logic autosleep_enable_i,
	input wire logic sample_tick_i,
	input wire logic [7:0] inactivity_limit_i,
	input wire logic activity_i,
	input wire logic wake_event_i,
	input wire logic [2:0] sleep_rate_i,
	input wire logic [2:0] wake_rate_i,
	output logic [1:0] mode_o,
	output logic [2:0] output_sample_rate_o,
	output logic transition_o
);

	msi_pkg::msi_mode_t mode_r;
	msi_pkg::msi_mode_t mode_nxt;
	logic [8:0] idle_r;
	logic [8:0] idle_nxt;
	logic [2:0] rate_r;
	logic [2:0] rate_nxt;
	logic trans_r;
	logic trans_nxt;
	logic idle_over;

	////////////////////////////////////////////////////////////////////////////////
	// Inactivity is measured in sample periods; the counter saturates so it never wraps.
	assign idle_over = idle_r > {1'b0, inactivity_limit_i};

	// Mode sequencing between standby, wake and sleep.
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			msi_pkg::MSI_MODE_STANDBY: begin
				if (active_i) begin
					mode_nxt = msi_pkg::MSI_MODE_WAKE;
				end
			end
			msi_pkg::MSI_MODE_WAKE: begin
				if (!active_i) begin
					mode_nxt = msi_pkg::MSI_MODE_STANDBY;
				end else if (autosleep_enable_i && idle_over && !activity_i) begin
					mode_nxt = msi_pkg::MSI_MODE_SLEEP;
				end
			end
			msi_pkg::MSI_MODE_SLEEP: begin
				if (!active_i) begin
					mode_nxt = msi_pkg::MSI_MODE_STANDBY;
				end else if (wake_event_i || !autosleep_enable_i) begin
					mode_nxt = msi_pkg::MSI_MODE_WAKE;
				end
			end
			default: begin
				mode_nxt = msi_pkg::MSI_MODE_STANDBY;
			end
		endcase
	end

	// Idle counter restarts on any activity and on every mode change.
	assign idle_nxt = (activity_i || mode_nxt != mode_r) ? msi_pkg::IDLE_COUNT_RESET :
		(sample_tick_i && idle_r != 9'h1FF) ? idle_r + msi_pkg::IDLE_COUNT_STEP : idle_r;
	// Sleep runs at the low rate, wake at the high rate.
	assign rate_nxt = (mode_nxt == msi_pkg::MSI_MODE_SLEEP) ? sleep_rate_i : wake_rate_i;
	// Only wake to sleep steps and sleep to wake steps caused by a wake event count as transitions.
	assign trans_nxt = (mode_r == msi_pkg::MSI_MODE_WAKE && mode_nxt == msi_pkg::MSI_MODE_SLEEP) ||
		(mode_r == msi_pkg::MSI_MODE_SLEEP && mode_nxt == msi_pkg::MSI_MODE_WAKE && wake_event_i);

	// State registers.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_r <= msi_pkg::MSI_MODE_STANDBY;
			idle_r <= msi_pkg::IDLE_COUNT_RESET;
			rate_r <= msi_pkg::RATE_RESET;
			trans_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			idle_r <= idle_nxt;
			rate_r <= rate_nxt;
			trans_r <= trans_nxt;
		end
	end

	assign mode_o = mode_r;
	assign output_sample_rate_o = rate_r;
	assign transition_o = trans_r;

endmodule

/* File: msi_int_source.sv */
// Interrupt source status register that gathers the embedded function events.

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Auto-sleep flag sets on an enabled wake-to-sleep transition or a sleep-to-wake transition caused by a wake event.
// - Enter sleep after inactivity beyond the limit, then run at the low rate.
// - Sleep state samples at the user-chosen low output rate.
// - A selected wake event during sleep returns to wake at the high rate.
// - Reading the system mode register clears the auto-sleep flag.
// - FIFO flag sets on overflow or count equal to watermark when enabled.
// - Reading the FIFO status register clears the FIFO flag.
// - Transient event means filtered acceleration above the programmed threshold.
// - Transient flag sets on transient event-active when enabled.
// - Reading the transient source register clears the transient flag.
// - Orientation flag sets on orientation-change bit when enabled.
// - Reading the orientation status register clears the orientation flag.
// - Tap flag sets on tap event-active when enabled.
// - Reading the tap source register clears the tap flag.
// - First fall/motion flag sets on its event-active when enabled.
// - Reading the first fall/motion source clears its flag.
// - Second fall/motion flag sets on its event-active when enabled.
// - Reading the second fall/motion source clears its flag.
// - Each flag latches on a rising event edge until its clearing read.
// - Eight-bit read-only register, auto-sleep in bit 7 down to bit 1.
// - FIFO overflow is a sample count of 32.
// - Watermark level zero disables the watermark event.
module msi_int_source (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic reg_rd_strobe_i,
	input wire logic [7:0] reg_rd_addr_i,
	output logic [7:0] reg_rd_data_o,
	input wire logic active_i,
	input wire logic autosleep_enable_i,
	input wire logic sample_tick_i,
	input wire logic [7:0] inactivity_limit_i,
	input wire logic [2:0] sleep_rate_i,
	input wire logic [2:0] wake_rate_i,
	input wire logic [7:1] int_enable_i,
	input wire logic [6:1] wake_enable_i,
	input wire logic [5:0] fifo_sample_count_i,
	input wire logic [5:0] fifo_watermark_level_i,
	input wire logic [11:0] transient_hp_mag_i,
	input wire logic [11:0] transient_threshold_i,
	input wire logic orientation_change_bit_i,
	input wire logic tap_event_active_i,
	input wire logic fall_motion_a_event_i,
	input wire logic fall_motion_b_event_i,
	input wire logic data_ready_flag_i,
	output logic [7:0] interrupt_source_status_o,
	output logic [1:0] system_mode_o,
	output logic [2:0] output_sample_rate_o,
	output logic transient_event_active_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic [7:0] rd_mux;
	logic [7:1] src_vec;
	logic [7:1] clr_vec;
	logic [7:1] flag_vec;
	logic [7:1] rise_vec;
	logic [1:0] mode;
	logic aslp_transition;
	logic fifo_overflow;
	logic fifo_watermark_hit;
	logic fifo_event;
	logic transient_active;
	logic activity;
	logic wake_event;
	logic hit_system_mode;
	logic hit_int_source;
	logic hit_orient_status;
	logic hit_fifo_status;
	logic hit_transient_source;
	logic hit_tap_source;
	logic hit_fall_a_source;
	logic hit_fall_b_source;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode of the register read port.
	assign hit_system_mode = reg_rd_addr_i == msi_pkg::REG_SYSTEM_MODE;
	assign hit_int_source = reg_rd_addr_i == msi_pkg::REG_INT_SOURCE;
	assign hit_orient_status = reg_rd_addr_i == msi_pkg::REG_ORIENT_STATUS;
	assign hit_fifo_status = reg_rd_addr_i == msi_pkg::REG_FIFO_STATUS;
	assign hit_transient_source = reg_rd_addr_i == msi_pkg::REG_TRANSIENT_SOURCE;
	assign hit_tap_source = reg_rd_addr_i == msi_pkg::REG_TAP_SOURCE;
	assign hit_fall_a_source = reg_rd_addr_i == msi_pkg::REG_FALL_A_SOURCE;
	assign hit_fall_b_source = reg_rd_addr_i == msi_pkg::REG_FALL_B_SOURCE;

	////////////////////////////////////////////////////////////////////////////////
	// Event generators of the individual functions.
	// Overflow is the full count; the watermark only fires for a non-zero level.
	assign fifo_overflow = fifo_sample_count_i == msi_pkg::FIFO_FULL_COUNT;
	assign fifo_watermark_hit = (fifo_watermark_level_i != msi_pkg::WATERMARK_OFF) &&
		(fifo_sample_count_i == fifo_watermark_level_i);
	assign fifo_event = fifo_overflow | fifo_watermark_hit;
	// Transient is active while the filtered magnitude is strictly above threshold.
	assign transient_active = transient_hp_mag_i > transient_threshold_i;
	assign transient_event_active_o = transient_active;

	// Source levels per flag position; the auto-sleep source is the transition pulse.
	assign src_vec[msi_pkg::BIT_AUTOSLEEP] = aslp_transition;
	assign src_vec[msi_pkg::BIT_FIFO] = fifo_event;
	assign src_vec[msi_pkg::BIT_TRANSIENT] = transient_active;
	assign src_vec[msi_pkg::BIT_ORIENT] = orientation_change_bit_i;
	assign src_vec[msi_pkg::BIT_TAP] = tap_event_active_i;
	assign src_vec[msi_pkg::BIT_FALL_A] = fall_motion_a_event_i;
	assign src_vec[msi_pkg::BIT_FALL_B] = fall_motion_b_event_i;

	////////////////////////////////////////////////////////////////////////////////
	// Clearing reads; each flag is cleared only by its own function's register.
	assign clr_vec[msi_pkg::BIT_AUTOSLEEP] = reg_rd_strobe_i & hit_system_mode;
	assign clr_vec[msi_pkg::BIT_FIFO] = reg_rd_strobe_i & hit_fifo_status;
	assign clr_vec[msi_pkg::BIT_TRANSIENT] = reg_rd_strobe_i & hit_transient_source;
	assign clr_vec[msi_pkg::BIT_ORIENT] = reg_rd_strobe_i & hit_orient_status;
	assign clr_vec[msi_pkg::BIT_TAP] = reg_rd_strobe_i & hit_tap_source;
	assign clr_vec[msi_pkg::BIT_FALL_A] = reg_rd_strobe_i & hit_fall_a_source;
	assign clr_vec[msi_pkg::BIT_FALL_B] = reg_rd_strobe_i & hit_fall_b_source;

	////////////////////////////////////////////////////////////////////////////////
	// One sticky edge flag per interrupt source.
	genvar gi;
	generate
		for (gi = msi_pkg::FLAG_LO; gi <= msi_pkg::FLAG_HI; gi = gi + 1) begin : g_flag
			msi_edge_flag u_flag (
				.ref_clk_i(ref_clk_i),
				.reset_n_i(reset_n_i),
				.src_i(src_vec[gi]),
				.enable_i(int_enable_i[gi]),
				.clear_i(clr_vec[gi]),
				.flag_o(flag_vec[gi]),
				.rise_o(rise_vec[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Any enabled function event restarts inactivity; selected ones also wake.
	assign activity = |rise_vec[msi_pkg::BIT_FIFO:msi_pkg::BIT_FALL_B];
	assign wake_event = |(rise_vec[msi_pkg::BIT_FIFO:msi_pkg::BIT_FALL_B] & wake_enable_i);

	// Auto-sleep and auto-wake controller.
	msi_sleep_ctrl u_sleep (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.active_i(active_i),
		.autosleep_enable_i(autosleep_enable_i),
		.sample_tick_i(sample_tick_i),
		.inactivity_limit_i(inactivity_limit_i),
		.activity_i(activity),
		.wake_event_i(wake_event),
		.sleep_rate_i(sleep_rate_i),
		.wake_rate_i(wake_rate_i),
		.mode_o(mode),
		.output_sample_rate_o(output_sample_rate_o),
		.transition_o(aslp_transition)
	);

	assign system_mode_o = mode;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt source status view: flags in bits 7 to 1, data ready in bit 0.
	assign interrupt_source_status_o = {flag_vec, data_ready_flag_i};

	// Read data selection; registers not held here read as zero.
	assign rd_mux = hit_int_source ? interrupt_source_status_o :
		hit_system_mode ? {6'h00, mode} :
		msi_pkg::UNMAPPED_READ;

	// The read data register loads on each read strobe and holds otherwise.
	assign rd_data_nxt = reg_rd_strobe_i ? rd_mux : rd_data_r;

	// Read data register.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_r <= msi_pkg::READ_DATA_RESET;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	assign reg_rd_data_o = rd_data_r;

endmodule

/* File: msi_host_model.sv */
// Host side model that issues single register reads on the internal read port.
module msi_host_model (
	input wire logic ref_clk_i,
	input wire logic [7:0] rd_data_i,
	output logic rd_strobe_o,
	output logic [7:0] rd_addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// The read port starts idle.
	initial begin
		rd_strobe_o = 1'h0;
		rd_addr_o = 8'h00;
	end
	// One read: a one-cycle strobe, data taken after the edge that takes it, then a scrambled idle address.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		rd_strobe_o <= 1'h1;
		rd_addr_o <= a;
		@(posedge ref_clk_i);
		rd_strobe_o <= 1'h0;
		rd_addr_o <= ~a;
		#1 d = rd_data_i;
	endtask
endmodule

/* File: msi_int_source_sva.sv */
// Checker of the interrupt source status block, seen from its top ports.
module msi_int_source_chk (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic reg_rd_strobe_i,
	input wire logic [7:0] reg_rd_addr_i,
	input wire logic [7:0] reg_rd_data_o,
	input wire logic autosleep_enable_i,
	input wire logic [2:0] sleep_rate_i,
	input wire logic [2:0] wake_rate_i,
	input wire logic [7:1] int_enable_i,
	input wire logic [5:0] fifo_sample_count_i,
	input wire logic [5:0] fifo_watermark_level_i,
	input wire logic [11:0] transient_hp_mag_i,
	input wire logic [11:0] transient_threshold_i,
	input wire logic orientation_change_bit_i,
	input wire logic tap_event_active_i,
	input wire logic [7:0] interrupt_source_status_o,
	input wire logic [1:0] system_mode_o,
	input wire logic [2:0] output_sample_rate_o,
	input wire logic transient_event_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	// Address of the read taken this cycle, and the combined FIFO event level.
	wire logic [7:0] rd_a = reg_rd_strobe_i ? reg_rd_addr_i : 8'h00;
	wire logic fifo_evt = (fifo_sample_count_i == 6'h20) ||
		(fifo_watermark_level_i != 6'h00 && fifo_sample_count_i == fifo_watermark_level_i);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////////////
	// Flags 7 to 2 against a cause, a clearing read or a hold; bit 1 is not checked.
	fifo_set_a: assert property ($rose(fifo_evt) && int_enable_i[6] |=> interrupt_source_status_o[6])
		else $error("fifo flag not set");
	fifo_clear_a: assert property (rd_a == 8'h40 && !($rose(fifo_evt) && int_enable_i[6]) |=> !interrupt_source_status_o[6])
		else $error("fifo flag not cleared");
	trans_compare_a: assert property (transient_event_active_o == (transient_hp_mag_i > transient_threshold_i))
		else $error("transient compare wrong");
	trans_set_a: assert property ($rose(transient_event_active_o) && int_enable_i[5] |=> interrupt_source_status_o[5])
		else $error("transient flag not set");
	orient_clear_a: assert property (rd_a == 8'h18 && !($rose(orientation_change_bit_i) && int_enable_i[4])
		|=> !interrupt_source_status_o[4])
		else $error("orientation flag not cleared");
	tap_set_a: assert property ($rose(tap_event_active_i) && int_enable_i[3] |=> interrupt_source_status_o[3])
		else $error("tap flag not set");
	fall_hold_a: assert property (interrupt_source_status_o[2] && rd_a != 8'h43 |=> interrupt_source_status_o[2])
		else $error("fall flag dropped");
	aslp_clear_a: assert property (rd_a == 8'h14 && system_mode_o == $past(system_mode_o)
		|=> !interrupt_source_status_o[7])
		else $error("auto-sleep flag not cleared");
	aslp_set_a: assert property (system_mode_o != $past(system_mode_o) && system_mode_o != 2'h0 &&
		$past(system_mode_o) != 2'h0 && $past(autosleep_enable_i) && int_enable_i[7] |=> interrupt_source_status_o[7])
		else $error("auto-sleep flag not set");
	sleep_rate_a: assert property (system_mode_o == 2'h2 |-> output_sample_rate_o == $past(sleep_rate_i))
		else $error("sleep rate wrong");
	wake_rate_a: assert property (system_mode_o == 2'h1 |-> output_sample_rate_o == $past(wake_rate_i))
		else $error("wake rate wrong");
	status_read_a: assert property (rd_a == 8'h15 |=> reg_rd_data_o == $past(interrupt_source_status_o))
		else $error("status read wrong");
endmodule
bind msi_int_source msi_int_source_chk chk_i (.ref_clk_i, .reset_n_i, .reg_rd_strobe_i, .reg_rd_addr_i,
	.reg_rd_data_o, .autosleep_enable_i, .sleep_rate_i, .wake_rate_i, .int_enable_i, .fifo_sample_count_i,
	.fifo_watermark_level_i,
	.transient_hp_mag_i, .transient_threshold_i, .orientation_change_bit_i, .tap_event_active_i,
	.interrupt_source_status_o, .system_mode_o, .output_sample_rate_o, .transient_event_active_o);

/* File: tb.sv */
// Self-checking testbench of the interrupt source status block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'h0, reset_n_i = 1'h0, reg_rd_strobe_i, active_i = 1'h0, autosleep_enable_i = 1'h0;
	logic sample_tick_i = 1'h0, orientation_change_bit_i = 1'h0, tap_event_active_i = 1'h0;
	logic fall_motion_a_event_i = 1'h0, fall_motion_b_event_i = 1'h0, data_ready_flag_i = 1'h0;
	logic transient_event_active_o;
	logic [7:0] reg_rd_addr_i, reg_rd_data_o, interrupt_source_status_o, d, inactivity_limit_i = 8'h02;
	logic [2:0] sleep_rate_i = 3'h2, wake_rate_i = 3'h5, output_sample_rate_o;
	logic [7:1] int_enable_i = 7'h7f;
	logic [6:1] wake_enable_i = 6'h00;
	logic [5:0] fifo_sample_count_i = 6'h00, fifo_watermark_level_i = 6'h00;
	logic [11:0] transient_hp_mag_i = 12'h100, transient_threshold_i = 12'h100;
	logic [1:0] system_mode_o;
	int miscompares = 0, n_tests = 0;
	typedef struct {int b; logic en; logic [7:0] ca;} msi_tb_row_t;
	msi_tb_row_t rows [8] = '{'{6, 1'h1, 8'h40}, '{5, 1'h1, 8'h41}, '{4, 1'h1, 8'h18}, '{3, 1'h1, 8'h42},
		'{2, 1'h1, 8'h43}, '{1, 1'h1, 8'h44}, '{3, 1'h0, 8'h42}, '{6, 1'h0, 8'h40}};
	msi_int_source DUT (.ref_clk_i, .reset_n_i, .reg_rd_strobe_i, .reg_rd_addr_i, .reg_rd_data_o, .active_i,
		.autosleep_enable_i, .sample_tick_i, .inactivity_limit_i, .sleep_rate_i, .wake_rate_i, .int_enable_i,
		.wake_enable_i, .fifo_sample_count_i, .fifo_watermark_level_i, .transient_hp_mag_i, .transient_threshold_i,
		.orientation_change_bit_i, .tap_event_active_i, .fall_motion_a_event_i, .fall_motion_b_event_i,
		.data_ready_flag_i, .interrupt_source_status_o, .system_mode_o, .output_sample_rate_o,
		.transient_event_active_o);
	msi_host_model host (.ref_clk_i, .rd_data_i(reg_rd_data_o), .rd_strobe_o(reg_rd_strobe_i),
		.rd_addr_o(reg_rd_addr_i));
	////////////////////////////////////////////////////////////////////////////////
	// Clock of 20 ns period.
	always #10 ref_clk_i = ~ref_clk_i;
	// Counts a comparison and reports a mismatch at once.
	task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Raises or drops the event source behind one status bit.
	task set_src(input int b, input logic v);
		case (b)
			6: fifo_sample_count_i <= v ? 6'h20 : 6'h00;
			5: transient_hp_mag_i <= v ? 12'h101 : 12'h100;
			4: orientation_change_bit_i <= v;
			3: tap_event_active_i <= v;
			2: fall_motion_a_event_i <= v;
			default: fall_motion_b_event_i <= v;
		endcase
	endtask
	// Waits a bounded time for the system mode to reach a value.
	task wait_mode(input logic [1:0] m);
		for (int k = 0; k < 60 && system_mode_o !== m; k++) begin
			@(posedge ref_clk_i);
			#1;
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, table of flag cases, then the awkward cases.
	initial begin
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'h1;
		#1 chk("status after reset", interrupt_source_status_o, 8'h00);
		chk("mode after reset", {6'h00, system_mode_o}, 8'h00);
		foreach (rows[i]) begin
			@(posedge ref_clk_i);
			int_enable_i[rows[i].b] <= rows[i].en;
			@(posedge ref_clk_i);
			set_src(rows[i].b, 1'h1);
			repeat (2) @(posedge ref_clk_i);
			host.rd(8'h15, d);
			chk("status read", d, 8'(rows[i].en) << rows[i].b);
			host.rd(rows[i].ca, d);
			chk("flag after clear", interrupt_source_status_o, 8'h00);
			@(posedge ref_clk_i);
			set_src(rows[i].b, 1'h0);
			int_enable_i[rows[i].b] <= 1'h1;
		end
		// Watermark equal to the count sets the flag; watermark zero and a count of 31 do not.
		@(posedge ref_clk_i);
		fifo_watermark_level_i <= 6'h05;
		fifo_sample_count_i <= 6'h05;
		repeat (2) @(posedge ref_clk_i);
		#1 chk("watermark flag", interrupt_source_status_o, 8'h40);
		host.rd(8'h40, d);
		fifo_watermark_level_i <= 6'h00;
		fifo_sample_count_i <= 6'h00;
		@(posedge ref_clk_i);
		fifo_sample_count_i <= 6'h1f;
		repeat (2) @(posedge ref_clk_i);
		#1 chk("watermark off", interrupt_source_status_o, 8'h00);
		chk("transient at threshold", {7'h00, transient_event_active_o}, 8'h00);
		// A new event in the cycle of its clearing read keeps the flag.
		fork
			host.rd(8'h42, d);
			begin
				@(posedge ref_clk_i);
				tap_event_active_i <= 1'h1;
			end
		join
		chk("tap kept", interrupt_source_status_o, 8'h08);
		host.rd(8'h42, d);
		chk("tap cleared", interrupt_source_status_o, 8'h00);
		data_ready_flag_i <= 1'h1;
		tap_event_active_i <= 1'h0;
		host.rd(8'h7f, d);
		chk("unmapped read", d, 8'h00);
		chk("ready bit", interrupt_source_status_o, 8'h01);
		// Auto-sleep after inactivity, then wake on a selected tap event.
		data_ready_flag_i <= 1'h0;
		active_i <= 1'h1;
		autosleep_enable_i <= 1'h1;
		sample_tick_i <= 1'h1;
		wait_mode(2'h2);
		chk("sleep rate", {5'h00, output_sample_rate_o}, 8'h02);
		repeat (2) @(posedge ref_clk_i);
		#1 chk("sleep flag", interrupt_source_status_o, 8'h80);
		host.rd(8'h14, d);
		chk("mode read", d, 8'h02);
		chk("sleep flag cleared", interrupt_source_status_o, 8'h00);
		wake_enable_i[3] <= 1'h1;
		@(posedge ref_clk_i);
		tap_event_active_i <= 1'h1;
		wait_mode(2'h1);
		chk("wake rate", {5'h00, output_sample_rate_o}, 8'h05);
		repeat (2) @(posedge ref_clk_i);
		#1 chk("wake flag", {interrupt_source_status_o[7], 7'h00}, 8'h80);
		// A reset in mid-run clears every flag.
		@(posedge ref_clk_i);
		autosleep_enable_i <= 1'h0;
		tap_event_active_i <= 1'h0;
		reset_n_i <= 1'h0;
		@(posedge ref_clk_i);
		#1 chk("status in reset", interrupt_source_status_o, 8'h00);
		reset_n_i <= 1'h1;
		// After the mid-run release the block wakes again with clean flags and a working read port.
		@(posedge ref_clk_i);
		#1 chk("rate after reset", {5'h00, output_sample_rate_o}, 8'h05);
		chk("status after release", interrupt_source_status_o, 8'h00);
		host.rd(8'h15, d);
		chk("status read after reset", d, 8'h00);
		repeat (2) @(posedge ref_clk_i);
		report_and_stop();
	end
	// Watchdog against a hang.
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end
endmodule
